/* hdl/sensor_params_pkg.sv */
// package: register map, field layout, reset values and timing for the sensor parameter block
package sensor_params_pkg;
	// register indices as printed; byte address is four times the index
	localparam logic [7:0] IDX_PROX_HYST    = 8'h17;
	localparam logic [7:0] IDX_PROX_HIST    = 8'h18;
	localparam logic [7:0] IDX_AMB_HIST     = 8'h19;
	localparam logic [7:0] IDX_RES_OFFSET   = 8'h1a;
	localparam logic [7:0] IDX_LED_PARAM    = 8'h1c;
	localparam logic [7:0] IDX_IR_RECOVERY  = 8'h1d;
	localparam logic [7:0] IDX_IR_GAIN      = 8'h1e;
	localparam logic [7:0] IDX_CONTROL      = 8'h20;
	localparam logic [7:0] IDX_STATUS       = 8'h21;
	localparam logic [7:0] IDX_IRQ_STATUS   = 8'h22;
	localparam logic [7:0] IDX_IRQ_MASK     = 8'h23;
	localparam logic [7:0] IDX_PROX_RESULT  = 8'h24;
	localparam logic [7:0] IDX_AMB_RESULT   = 8'h25;
	localparam logic [7:0] IDX_IR_RESULT    = 8'h26;

	localparam logic [7:0] RST_PROX_HYST    = 8'h48;
	localparam logic [7:0] RST_PROX_HIST    = 8'h00;
	localparam logic [7:0] RST_AMB_HIST     = 8'h03;
	localparam logic [7:0] RST_RES_OFFSET   = 8'h00;
	localparam logic [7:0] RST_LED_PARAM    = 8'h00;
	localparam logic [7:0] RST_IR_RECOVERY  = 8'h70;
	localparam logic [7:0] RST_IR_GAIN      = 8'h00;

	// recovery code in bits 6:4 of its register; gain in bits 2:0
	localparam int REC_LSB  = 4;
	localparam int REC_MSB  = 6;
	localparam int GAIN_MSB = 2;
	localparam logic [7:0] REC_WMASK  = 8'h70;
	localparam logic [7:0] GAIN_WMASK = 8'h07;
	localparam logic [15:0] OVERRANGE = 16'hffff;

	// interrupt status bits
	localparam int IRQ_PROX    = 0;
	localparam int IRQ_AMB     = 1;
	localparam int IRQ_IR_DONE = 2;
	localparam int IRQ_W       = 3;

	// one adc clock is 50 ns nominal, rounded up to ADC_DIV whole mclk periods (60 ns)
	localparam int ADC_CLK_NS = 50;
	localparam int MCLK_NS    = 20;
	localparam int ADC_DIV    = (ADC_CLK_NS + MCLK_NS - 1) / MCLK_NS;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// one sample from the converter front end
	typedef struct packed {
		logic        proxValid;
		logic [1:0]  proxChannel;
		logic [15:0] proxRaw;
		logic [15:0] proxThreshold;
		logic        ambValid;
		logic [15:0] ambRaw;
		logic [15:0] ambThreshold;
	} sample_t;
endpackage

/* hdl/sensor_threshold_history_params.sv */
// sensor parameter registers, history filters, result offset and ir recovery timer
`timescale 1ns/10ps
`default_nettype none
module sensor_threshold_history_params #(
	parameter int ADDR_W     = 8,
	parameter int INTEG_CLKS = 16
) (
	input  wire logic                         mclk,
	input  wire logic                         rst,
	input  wire logic [ADDR_W-1:0]            awaddr,
	input  wire logic                         awvalid,
	output logic                              awready,
	input  wire logic [31:0]                  wdata,
	input  wire logic [3:0]                   wstrb,
	input  wire logic                         wvalid,
	output logic                              wready,
	output logic [1:0]                        bresp,
	output logic                              bvalid,
	input  wire logic                         bready,
	input  wire logic [ADDR_W-1:0]            araddr,
	input  wire logic                         arvalid,
	output logic                              arready,
	output logic [31:0]                       rdata,
	output logic [1:0]                        rresp,
	output logic                              rvalid,
	input  wire logic                         rready,
	input  wire sensor_params_pkg::sample_t   sample,
	input  wire logic                         irStart,
	input  wire logic [15:0]                  irRaw,
	output logic                              proxStatus,
	output logic                              ambStatus,
	output logic [15:0]                       proxResult,
	output logic [15:0]                       ambResult,
	output logic                              irBusy,
	output logic                              irSampleEn,
	output logic                              irDone,
	output logic                              irq
);
	typedef enum logic [1:0] {IR_IDLE, IR_RECOVER, IR_INTEG} ir_state_t;

	logic [7:0] proxHyst_reg, proxHist_reg, ambHist_reg, resOffset_reg;
	logic [7:0] ledParam_reg, irRecovery_reg, irGain_reg;
	logic       enable_reg;
	logic [ADDR_W-1:0] awAddr_reg;
	logic       awHave_reg, wHave_reg;
	logic [31:0] wData_reg;
	logic [3:0]  wStrb_reg;
	localparam int IRQ_W_L = sensor_params_pkg::IRQ_W;
	logic [IRQ_W_L-1:0] irqStatus_reg, irqMask_reg, irqEvents;
	logic [7:0] proxShift_reg [3];
	logic [7:0] ambShift_reg;
	logic [2:0] proxChanStat_reg;
	logic [15:0] irResult_reg;
	ir_state_t  irState_reg;
	logic [9:0] adcTick_reg;
	logic [9:0] recCnt_reg;
	logic [15:0] integCnt_reg;
	logic [7:0] adcDiv_reg;
	logic       adcTick;
	logic       wrFire;
	logic [7:0] wrIdx;

	// expand 8-bit compressed code to 16 bits
	function automatic logic [15:0] decompress(input logic [7:0] code);
		logic [31:0] full;
		full = {27'h0, 1'b1, code[3:0]} << code[7:4];
		return full[19:4];
	endfunction

	// add offset, keeping ordinary values off the overrange code
	function automatic logic [15:0] addOffset(input logic [15:0] raw,
		input logic [7:0] code);
		logic [16:0] sum;
		sum = {1'b0, raw} + {1'b0, decompress(code)};
		if (sum >= {1'b0, sensor_params_pkg::OVERRANGE}) begin
			return sensor_params_pkg::OVERRANGE - 16'h0001;
		end
		return sum[15:0];
	endfunction

	// history mask test: all selected history bits set
	function automatic logic histMet(input logic [7:0] hist,
		input logic [7:0] mask);
		return (mask != 8'h00) && ((hist & mask) == mask);
	endfunction

	// recovery length in adc clocks
	function automatic logic [9:0] recClocks(input logic [2:0] code);
		if (code == 3'h0) begin
			return 10'h001;
		end
		return (10'h001 << (4'(code) + 4'h2)) - 10'h001;
	endfunction

	assign wrFire = awHave_reg && wHave_reg && !bvalid;
	assign wrIdx  = 8'(awAddr_reg >> 2);

	// write address and data channels, taken in either order
	always_ff @(posedge mclk) begin
		if (rst) begin
			awHave_reg <= 1'b0;
			wHave_reg  <= 1'b0;
			awAddr_reg <= '0;
			wData_reg  <= 32'h0;
			wStrb_reg  <= 4'h0;
			bvalid     <= 1'b0;
			bresp      <= sensor_params_pkg::RESP_OKAY;
			awready    <= 1'b1;
			wready     <= 1'b1;
		end else begin
			if (awvalid && awready) begin
				awHave_reg <= 1'b1;
				awAddr_reg <= awaddr;
				awready    <= 1'b0;
			end
			if (wvalid && wready) begin
				wHave_reg <= 1'b1;
				wData_reg <= wdata;
				wStrb_reg <= wstrb;
				wready    <= 1'b0;
			end
			if (wrFire) begin
				awHave_reg <= 1'b0;
				wHave_reg  <= 1'b0;
				awready    <= 1'b1;
				wready     <= 1'b1;
				bvalid     <= 1'b1;
				bresp      <= regKnown(wrIdx) ? sensor_params_pkg::RESP_OKAY
					: sensor_params_pkg::RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	function automatic logic regKnown(input logic [7:0] idx);
		return idx inside {sensor_params_pkg::IDX_PROX_HYST,
			sensor_params_pkg::IDX_PROX_HIST, sensor_params_pkg::IDX_AMB_HIST,
			sensor_params_pkg::IDX_RES_OFFSET, sensor_params_pkg::IDX_LED_PARAM,
			sensor_params_pkg::IDX_IR_RECOVERY, sensor_params_pkg::IDX_IR_GAIN,
			sensor_params_pkg::IDX_CONTROL, sensor_params_pkg::IDX_STATUS,
			sensor_params_pkg::IDX_IRQ_STATUS, sensor_params_pkg::IDX_IRQ_MASK,
			sensor_params_pkg::IDX_PROX_RESULT, sensor_params_pkg::IDX_AMB_RESULT,
			sensor_params_pkg::IDX_IR_RESULT};
	endfunction

	// parameter registers, low byte lane only
	always_ff @(posedge mclk) begin
		if (rst) begin
			proxHyst_reg   <= sensor_params_pkg::RST_PROX_HYST;
			proxHist_reg   <= sensor_params_pkg::RST_PROX_HIST;
			ambHist_reg    <= sensor_params_pkg::RST_AMB_HIST;
			resOffset_reg  <= sensor_params_pkg::RST_RES_OFFSET;
			ledParam_reg   <= sensor_params_pkg::RST_LED_PARAM;
			irRecovery_reg <= sensor_params_pkg::RST_IR_RECOVERY;
			irGain_reg     <= sensor_params_pkg::RST_IR_GAIN;
			enable_reg     <= 1'b0;
			irqMask_reg    <= '0;
		end else if (wrFire && wStrb_reg[0]) begin
			unique case (wrIdx)
				sensor_params_pkg::IDX_PROX_HYST: proxHyst_reg <= wData_reg[7:0];
				sensor_params_pkg::IDX_PROX_HIST: proxHist_reg <= wData_reg[7:0];
				sensor_params_pkg::IDX_AMB_HIST: ambHist_reg <= wData_reg[7:0];
				sensor_params_pkg::IDX_RES_OFFSET: resOffset_reg <= wData_reg[7:0];
				sensor_params_pkg::IDX_LED_PARAM: ledParam_reg <= wData_reg[7:0];
				sensor_params_pkg::IDX_IR_RECOVERY: begin
					irRecovery_reg <= wData_reg[7:0] & sensor_params_pkg::REC_WMASK;
				end
				sensor_params_pkg::IDX_IR_GAIN: begin
					irGain_reg <= wData_reg[7:0] & sensor_params_pkg::GAIN_WMASK;
				end
				sensor_params_pkg::IDX_CONTROL: enable_reg <= wData_reg[0];
				sensor_params_pkg::IDX_IRQ_MASK: irqMask_reg <= wData_reg[IRQ_W_L-1:0];
				default: ;
			endcase
		end
	end

	// read channel
	always_ff @(posedge mclk) begin
		if (rst) begin
			rvalid  <= 1'b0;
			arready <= 1'b0;
			rdata   <= 32'h0;
			rresp   <= sensor_params_pkg::RESP_OKAY;
		end else begin
			arready <= 1'b0;
			if (rvalid) begin
				if (rready) begin
					rvalid <= 1'b0;
				end
			end else if (arvalid && !arready) begin
				arready <= 1'b1;
				rvalid  <= 1'b1;
				rresp   <= regKnown(8'(araddr >> 2)) ? sensor_params_pkg::RESP_OKAY
					: sensor_params_pkg::RESP_SLVERR;
				unique case (8'(araddr >> 2))
					sensor_params_pkg::IDX_PROX_HYST: rdata <= {24'h0, proxHyst_reg};
					sensor_params_pkg::IDX_PROX_HIST: rdata <= {24'h0, proxHist_reg};
					sensor_params_pkg::IDX_AMB_HIST: rdata <= {24'h0, ambHist_reg};
					sensor_params_pkg::IDX_RES_OFFSET: rdata <= {24'h0, resOffset_reg};
					sensor_params_pkg::IDX_LED_PARAM: rdata <= {24'h0, ledParam_reg};
					sensor_params_pkg::IDX_IR_RECOVERY: begin
						rdata <= {24'h0, irRecovery_reg};
					end
					sensor_params_pkg::IDX_IR_GAIN: rdata <= {24'h0, irGain_reg};
					sensor_params_pkg::IDX_CONTROL: rdata <= {31'h0, enable_reg};
					sensor_params_pkg::IDX_STATUS: begin
						rdata <= {26'h0, irBusy, ambStatus, proxChanStat_reg, proxStatus};
					end
					sensor_params_pkg::IDX_IRQ_STATUS: rdata <= {29'h0, irqStatus_reg};
					sensor_params_pkg::IDX_IRQ_MASK: rdata <= {29'h0, irqMask_reg};
					sensor_params_pkg::IDX_PROX_RESULT: rdata <= {16'h0, proxResult};
					sensor_params_pkg::IDX_AMB_RESULT: rdata <= {16'h0, ambResult};
					sensor_params_pkg::IDX_IR_RESULT: rdata <= {16'h0, irResult_reg};
					default: rdata <= 32'h0;
				endcase
			end
		end
	end

	// proximity filter: one history per channel, shared hysteresis
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < 3; i++) begin
				proxShift_reg[i] <= 8'h00;
			end
			proxChanStat_reg <= 3'h0;
			proxResult       <= 16'h0;
		end else if (enable_reg && sample.proxValid && sample.proxChannel != 2'h3) begin
			logic [15:0] res;
			logic [16:0] lim;
			logic        over;
			logic [7:0]  hist;
			res  = addOffset(sample.proxRaw, resOffset_reg);
			lim  = {1'b0, sample.proxThreshold} + {1'b0, decompress(proxHyst_reg)};
			over = {1'b0, res} > lim;
			hist = {proxShift_reg[sample.proxChannel][6:0], over};
			proxShift_reg[sample.proxChannel] <= hist;
			proxResult <= res;
			if (histMet(hist, proxHist_reg)) begin
				proxChanStat_reg[sample.proxChannel] <= 1'b1;
			end else if (histMet(~hist, proxHist_reg)) begin
				proxChanStat_reg[sample.proxChannel] <= 1'b0;
			end
		end
	end

	// ambient filter
	always_ff @(posedge mclk) begin
		if (rst) begin
			ambShift_reg <= 8'h00;
			ambStatus    <= 1'b0;
			ambResult    <= 16'h0;
		end else if (enable_reg && sample.ambValid) begin
			logic [15:0] res;
			logic [7:0]  hist;
			res  = addOffset(sample.ambRaw, resOffset_reg);
			hist = {ambShift_reg[6:0],
				{1'b0, res} > ({1'b0, sample.ambThreshold} + 17'(decompress(proxHyst_reg)))};
			ambShift_reg <= hist;
			ambResult    <= res;
			if (histMet(hist, ambHist_reg)) begin
				ambStatus <= 1'b1;
			end else if (histMet(~hist, ambHist_reg)) begin
				ambStatus <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			proxStatus <= 1'b0;
		end else begin
			proxStatus <= |proxChanStat_reg;
		end
	end

	// adc clock: one tick every ADC_DIV mclk cycles (60 ns), stretched by 2^gain
	always_ff @(posedge mclk) begin
		if (rst || irState_reg == IR_IDLE) begin
			adcDiv_reg  <= 8'h0;
			adcTick_reg <= 10'h0;
		end else if (adcDiv_reg == 8'(sensor_params_pkg::ADC_DIV - 1)) begin
			adcDiv_reg <= 8'h0;
			if (adcTick_reg == 10'((1 << irGain_reg[sensor_params_pkg::GAIN_MSB:0]) - 1)) begin
				adcTick_reg <= 10'h0;
			end else begin
				adcTick_reg <= adcTick_reg + 10'h001;
			end
		end else begin
			adcDiv_reg <= adcDiv_reg + 8'h01;
		end
	end

	assign adcTick = (adcDiv_reg == 8'(sensor_params_pkg::ADC_DIV - 1)) &&
		(adcTick_reg == 10'((1 << irGain_reg[sensor_params_pkg::GAIN_MSB:0]) - 1));

	// ir ambient sequence: recover, then integrate
	always_ff @(posedge mclk) begin
		if (rst) begin
			irState_reg  <= IR_IDLE;
			recCnt_reg   <= 10'h0;
			integCnt_reg <= 16'h0;
			irBusy       <= 1'b0;
			irSampleEn   <= 1'b0;
			irDone       <= 1'b0;
			irResult_reg <= 16'h0;
		end else begin
			irDone <= 1'b0;
			unique case (irState_reg)
				IR_IDLE: begin
					if (enable_reg && irStart) begin
						irState_reg <= IR_RECOVER;
						irBusy      <= 1'b1;
						recCnt_reg  <= recClocks(
							irRecovery_reg[sensor_params_pkg::REC_MSB:sensor_params_pkg::REC_LSB]);
					end
				end
				IR_RECOVER: begin
					if (adcTick) begin
						if (recCnt_reg == 10'h001) begin
							irState_reg  <= IR_INTEG;
							irSampleEn   <= 1'b1;
							integCnt_reg <= 16'(INTEG_CLKS);
						end else begin
							recCnt_reg <= recCnt_reg - 10'h001;
						end
					end
				end
				IR_INTEG: begin
					// tick already scaled by 2^gain
					if (adcTick) begin
						if (integCnt_reg == 16'h0001) begin
							irState_reg  <= IR_IDLE;
							irSampleEn   <= 1'b0;
							irBusy       <= 1'b0;
							irDone       <= 1'b1;
							irResult_reg <= addOffset(irRaw, resOffset_reg);
						end else begin
							integCnt_reg <= integCnt_reg - 16'h0001;
						end
					end
				end
			endcase
		end
	end

	// sticky events, write one to clear, set wins
	always_comb begin
		irqEvents = '0;
		irqEvents[sensor_params_pkg::IRQ_PROX] = proxStatus != (|proxChanStat_reg);
		irqEvents[sensor_params_pkg::IRQ_AMB]  = enable_reg && sample.ambValid &&
			(ambStatus != histMet(~8'h0, 8'h0));
		irqEvents[sensor_params_pkg::IRQ_IR_DONE] = irDone;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			irqStatus_reg <= '0;
			irq           <= 1'b0;
		end else begin
			logic [IRQ_W_L-1:0] clr;
			clr = (wrFire && wStrb_reg[0] && wrIdx == sensor_params_pkg::IDX_IRQ_STATUS)
				? wData_reg[IRQ_W_L-1:0] : '0;
			irqStatus_reg <= (irqStatus_reg & ~clr) | irqEvents;
			irq <= |(((irqStatus_reg & ~clr) | irqEvents) & irqMask_reg);
		end
	end
endmodule
`default_nettype wire

/* tb/sensor_params_props.sv */
// checker: bus handshake, result and ir timing assertions
`timescale 1ns/10ps
`default_nettype none
module sensor_params_props (
	input wire logic                       mclk,
	input wire logic                       rst,
	input wire logic                       awvalid,
	input wire logic                       awready,
	input wire logic                       wvalid,
	input wire logic                       wready,
	input wire logic [1:0]                 bresp,
	input wire logic                       bvalid,
	input wire logic                       bready,
	input wire logic                       arvalid,
	input wire logic                       arready,
	input wire logic [31:0]                rdata,
	input wire logic [1:0]                 rresp,
	input wire logic                       rvalid,
	input wire logic                       rready,
	input wire sensor_params_pkg::sample_t sample,
	input wire logic                       ambStatus,
	input wire logic [15:0]                proxResult,
	input wire logic [15:0]                ambResult,
	input wire logic                       irBusy,
	input wire logic                       irSampleEn,
	input wire logic                       irDone
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_recover; !irSampleEn [*3]; endsequence
	sequence s_integ; irSampleEn [*3]; endsequence
	property p_rd;
		arvalid && !arready && !rvalid |=> arready && rvalid;
	endproperty
	property p_rhold;
		rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
	endproperty
	property p_rzero; rvalid |-> rdata[31:16] == 16'h0000; endproperty
	property p_wr;
		awvalid && awready && wvalid && wready |-> ##[1:2] bvalid;
	endproperty
	property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	property p_ovr;
		ambResult != 16'hffff && proxResult != 16'hffff;
	endproperty
	property p_en; irSampleEn |-> irBusy; endproperty
	property p_rec; $rose(irBusy) |-> s_recover; endproperty
	property p_integ; $rose(irSampleEn) |-> s_integ; endproperty
	property p_done; irDone |=> !irDone; endproperty
	property p_amb;
		$rose(ambStatus) |-> $past(sample.ambValid) ||
			$past(sample.ambValid, 2) || $past(sample.ambValid, 3);
	endproperty
	a_rd: assert property (p_rd) else $error("read answer late");
	a_rhold: assert property (p_rhold) else $error("read data moved");
	a_rzero: assert property (p_rzero) else $error("upper bits set");
	a_wr: assert property (p_wr) else $error("write answer late");
	a_bhold: assert property (p_bhold) else $error("write resp moved");
	a_ovr: assert property (p_ovr) else $error("overrange code seen");
	a_en: assert property (p_en) else $error("sampling while idle");
	a_rec: assert property (p_rec) else $error("recovery too short");
	a_integ: assert property (p_integ) else $error("integ too short");
	a_done: assert property (p_done) else $error("done not a pulse");
	a_amb: assert property (p_amb) else $error("status without sample");
endmodule
bind sensor_threshold_history_params sensor_params_props i_props (.*);
`default_nettype wire

/* tb/axil_host.sv */
// partner model: register host driving the slave bus
`timescale 1ns/10ps
`default_nettype none
module axil_host (
	input wire logic        mclk,
	output logic [7:0]      awaddr = 8'h00,
	output logic            awvalid = 1'b0,
	input wire logic        awready,
	output logic [31:0]     wdata = 32'h00000000,
	output logic [3:0]      wstrb = 4'h0,
	output logic            wvalid = 1'b0,
	input wire logic        wready,
	input wire logic [1:0]  bresp,
	input wire logic        bvalid,
	output logic            bready = 1'b0,
	output logic [7:0]      araddr = 8'h00,
	output logic            arvalid = 1'b0,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  rresp,
	input wire logic        rvalid,
	output logic            rready = 1'b0
);
	task automatic wr(input logic [7:0] idx, input logic [7:0] d,
		output logic [1:0] r);
		logic b;
		awaddr <= {idx[5:0], 2'b00};
		wdata <= {24'h000000, d};
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge mclk);
			b = bvalid;
			r = bresp;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!b);
		bready <= 1'b0;
		@(posedge mclk);
	endtask
	// each request is dropped at the edge where its ready is seen high
	task automatic rd(input logic [7:0] idx, output logic [7:0] d,
		output logic [1:0] r);
		logic v;
		araddr <= {idx[5:0], 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge mclk);
			v = rvalid;
			d = rdata[7:0];
			r = rresp;
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!v);
		rready <= 1'b0;
		@(posedge mclk);
	endtask
endmodule
`default_nettype wire

/* tb/sensor_threshold_history_params_tb.sv */
// testbench: register map, history filters, offsets and ir timing
`timescale 1ns/10ps
`default_nettype none
module sensor_threshold_history_params_tb;
	localparam int INTEG = 4;
	typedef struct packed {
		logic [7:0] idx;
		logic       wr;
		logic [7:0] d;
		logic [7:0] e;
	} row_t;
	row_t rows[11] = '{'{8'h17, 0, 0, 8'h48}, '{8'h18, 0, 0, 8'h00},
		'{8'h19, 0, 0, 8'h03}, '{8'h1a, 0, 0, 8'h00},
		'{8'h1c, 0, 0, 8'h00}, '{8'h1d, 0, 0, 8'h70},
		'{8'h1e, 0, 0, 8'h00}, '{8'h1c, 1, 8'ha5, 8'ha5},
		'{8'h1d, 1, 8'hff, 8'h70}, '{8'h1e, 1, 8'hff, 8'h07},
		'{8'h18, 1, 8'h07, 8'h07}};
	logic [7:0] masks[3] = '{8'h03, 8'h07, 8'hff};
	int         hn[3] = '{2, 3, 8};
	logic [2:0] recs[4] = '{3'd0, 3'd1, 3'd6, 3'd0};
	logic [2:0] gains[4] = '{3'd0, 3'd0, 3'd1, 3'd7};
	int         recClk[4] = '{3, 21, 1530, 384};
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awaddr, araddr, d;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	sensor_params_pkg::sample_t sample = '0;
	logic irStart = 1'b0;
	logic [15:0] irRaw = 16'h1234;
	logic proxStatus, ambStatus, irBusy, irSampleEn, irDone, irq;
	logic [15:0] proxResult, ambResult;
	int mismatches = 0;
	int checked = 0;
	int cyc = 0;
	int n;
	int c;
	always #10 mclk = ~mclk;
	axil_host i_axil_host (.*);
	sensor_threshold_history_params #(.INTEG_CLKS(INTEG))
		i_sensor_threshold_history_params (.*);
	task automatic check(input string nm, input logic [31:0] got,
		input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// one sample pulse, then time for the status pipeline to settle
	task automatic samp(input logic p, input logic [15:0] raw);
		sample.proxValid <= p;
		sample.ambValid <= !p;
		sample.proxChannel <= 2'd2;
		sample.proxRaw <= raw;
		sample.ambRaw <= raw;
		@(posedge mclk);
		sample.proxValid <= 1'b0;
		sample.ambValid <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc > 40000) begin
			mismatches++;
			wrap_up();
		end
	end
	initial begin
		sample.proxThreshold = 16'd100;
		sample.ambThreshold = 16'd100;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		foreach (rows[i]) begin
			if (rows[i].wr) i_axil_host.wr(rows[i].idx, rows[i].d, r);
			i_axil_host.rd(rows[i].idx, d, r);
			check($sformatf("reg %h", rows[i].idx), 32'(d), 32'(rows[i].e));
		end
		i_axil_host.rd(8'h1b, d, r);
		check("unmapped read", 32'(r), 32'(sensor_params_pkg::RESP_SLVERR));
		i_axil_host.wr(8'h1b, 8'hff, r);
		check("unmapped write", 32'(r), 32'(sensor_params_pkg::RESP_SLVERR));
		$display("register table done");
		i_axil_host.wr(8'h1e, 8'h00, r);
		i_axil_host.wr(8'h20, 8'h01, r);
		for (int p = 0; p < 2; p++) begin
			for (int k = 0; k < 3; k++) begin
				i_axil_host.wr((p == 1) ? 8'h18 : 8'h19, masks[k], r);
				// offset code zero still adds one: 123 lands on the limit
				repeat (8) samp(p[0], 16'd123);
				repeat (hn[k] - 1) samp(p[0], 16'd124);
				check("status early", 32'((p == 1) ? proxStatus : ambStatus), 0);
				samp(p[0], 16'd124);
				check("status set", 32'((p == 1) ? proxStatus : ambStatus), 1);
			end
		end
		$display("history filters done");
		for (int k = 0; k < 3; k++) begin
			i_axil_host.wr(8'h1a, 8'h60 + 8'(k * 16), r);
			samp(1'b0, 16'd10);
			check("offset result", 32'(ambResult), 32'(10 + (64 << k)));
		end
		samp(1'b0, 16'hffff);
		check("amb saturated", 32'(ambResult), 32'h0000fffe);
		samp(1'b1, 16'hfff0);
		check("prox saturated", 32'(proxResult), 32'h0000fffe);
		$display("offsets done");
		for (int k = 0; k < 4; k++) begin
			i_axil_host.wr(8'h1d, {1'b0, recs[k], 4'h0}, r);
			i_axil_host.wr(8'h1e, {5'h00, gains[k]}, r);
			i_axil_host.wr(8'h22, 8'h07, r);
			i_axil_host.wr(8'h23, (k > 0) ? 8'h04 : 8'h00, r);
			irStart <= 1'b1;
			@(posedge mclk);
			irStart <= 1'b0;
			n = 0;
			c = 0;
			while (!irDone) begin
				@(negedge mclk);
				n = n + int'(irBusy && !irSampleEn);
				c = c + int'(irSampleEn);
			end
			check("recovery clocks", 32'(n), 32'(recClk[k]));
			check("integ clocks", 32'(c), 32'((3 * INTEG) << gains[k]));
			repeat (3) @(posedge mclk);
			check("irq level", 32'(irq), 32'(k > 0));
			i_axil_host.rd(8'h22, d, r);
			check("ir done flag", 32'(d[2]), 1);
			i_axil_host.rd(8'h26, d, r);
			check("ir result", 32'(d), 32'(8'(irRaw + 16'd256)));
			i_axil_host.wr(8'h22, 8'h04, r);
			repeat (2) @(posedge mclk);
			check("irq cleared", 32'(irq), 0);
		end
		$display("ir recovery done");
		i_axil_host.wr(8'h17, 8'h11, r);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		check("irq after reset", 32'(irq), 0);
		check("amb after reset", 32'(ambStatus), 0);
		i_axil_host.rd(8'h17, d, r);
		check("hyst after reset", 32'(d), 32'(8'h48));
		$display("mid-run reset done");
		wrap_up();
	end
endmodule
`default_nettype wire
